// file: ducr_consts.vh
// Constants for the converter update, clear and reset control block.
// Assumes a 250 MHz core clock; times are held in nanoseconds.
`ifndef DUCR_CONSTS_VH
`define DUCR_CONSTS_VH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define DUCR_CLK_PERIOD_NS   4
`define DUCR_CLR_TIME16_NS   20000
`define DUCR_CLR_TIME8_NS    15000
`define DUCR_RST_TIME_NS     270000
`define DUCR_CLR_CYC16       (`DUCR_CLR_TIME16_NS / `DUCR_CLK_PERIOD_NS)
`define DUCR_CLR_CYC8        (`DUCR_CLR_TIME8_NS / `DUCR_CLK_PERIOD_NS)
`define DUCR_RST_CYC         (`DUCR_RST_TIME_NS / `DUCR_CLK_PERIOD_NS)
`define DUCR_CALC_CYC        16
// ----------------------------------------
// Serial frame
// ----------------------------------------
`define DUCR_FRAME_BITS      24
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DUCR_CTRL_RST        8'h00
`define DUCR_MON_RST         5'h00
`define DUCR_CLRCODE_RST     14'h0000
// ----------------------------------------
// Control word field positions
// ----------------------------------------
`define DUCR_CTRL_INTREF     0
`define DUCR_CTRL_MONEN      1
`endif

// file: ducr_control.v
// Update, clear and reset control of a multi-channel voltage-output converter.
// Pins from the host arrive asynchronously and pass two flip-flops first.
`timescale 1ns/1ps
`default_nettype none
`include "ducr_consts.vh"

// Functional notes
// RQ1: Frame select low starts serial clock counter
// RQ2: Two-wire mode: two pins form address
// RQ3: Cascade enable high enables daisy chain
// RQ4: Serial output changes on rising clock edge
// RQ5: Busy low during calc; queue writes, block updates
// RQ6: Load request while not busy updates immediately
// RQ7: Load request during calc remembered, done later
// RQ8: Reset low: busy low, interface off, loads dropped
// RQ9: Clear on falling edge; loads ignored while low; code takes the edge only while not busy
// RQ10: Clear loads clear code, busy 20/15 us
// RQ11: Reset falling edge restores registers within 270us
// RQ12: Busy low through reset sequence, interfaces disabled
// RQ13: After reset ignore reset level until edge
// RQ14: Monitor selects one of 16 or 8 channels
// RQ15: Monitor may select either monitor input too
// RQ16: Reference bit selectable; default external input
// RQ17: Interface select low two-wire, high serial
// RQ18: Host presents data valid at falling edge
// RQ19: Host interface stays active during power-down
// RQ20: Deferred load requests collapse into one update
module ducr_control #(
	parameter CHANNELS = 16,
	parameter RST_CYC  = `DUCR_RST_CYC,
	parameter CLR_CYC  = (CHANNELS == 16) ? `DUCR_CLR_CYC16 : `DUCR_CLR_CYC8,
	parameter CALC_CYC = `DUCR_CALC_CYC
) (
	// Clock and reset
	input  wire        CORE_CLK,
	input  wire        RST_N,
	// Host pins
	input  wire        INTERFACE_SERIAL,
	input  wire        SERIAL_CLK,
	input  wire        SERIAL_DATA_IN,
	input  wire        FRAME_SELECT_ADDR_BIT0,
	input  wire        CASCADE_ENABLE_ADDR_BIT1,
	input  wire        LOAD_OUTPUTS_N,
	input  wire        CLEAR_TO_CODE_N,
	input  wire        RESET_PIN_N,
	input  wire        POWER_DOWN,
	// Serial output, three-state
	output reg         SERIAL_DATA_OUT,
	output reg         SERIAL_DATA_OUT_OE,
	// Status and converter control
	output reg         BUSY_N,
	output reg         LOAD_OUTPUTS_STROBE,
	output reg         CLEAR_STROBE,
	output reg         REG_RESET_STROBE,
	output reg         FRAME_DONE,
	output reg  [23:0] FRAME_WORD,
	output reg  [1:0]  BUS_ADDRESS,
	output reg         POWER_DOWN_ACTIVE,
	// Monitor, reference and clear code
	output reg         MONITOR_ENABLE,
	output reg  [4:0]  MONITOR_SELECT,
	output reg         INTERNAL_REF_ENABLE,
	output reg  [13:0] CLEAR_CODE
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam NSYNC = 9;
	wire [NSYNC-1:0] raw_w = {INTERFACE_SERIAL, SERIAL_CLK, SERIAL_DATA_IN,
		FRAME_SELECT_ADDR_BIT0, CASCADE_ENABLE_ADDR_BIT1, LOAD_OUTPUTS_N,
		CLEAR_TO_CODE_N, RESET_PIN_N, POWER_DOWN};
	reg [NSYNC-1:0] meta_q;
	reg [NSYNC-1:0] sync_q;
	reg [NSYNC-1:0] prev_q;

	// Reset value is each pin's idle level, so no false edge follows reset
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			meta_q <= 9'h1ee;
			sync_q <= 9'h1ee;
			prev_q <= 9'h1ee;
		end else begin
			meta_q <= raw_w;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	wire serial_mode = sync_q[8];
	wire sclk_rise   = sync_q[7] & ~prev_q[7];
	wire sclk_fall   = ~sync_q[7] & prev_q[7];
	wire sdin        = sync_q[6];
	wire frame_n     = sync_q[5];
	wire cascade     = sync_q[4];
	wire load_fall   = ~sync_q[3] & prev_q[3];
	wire clr_low     = ~sync_q[2];
	wire clr_fall    = ~sync_q[2] & prev_q[2];
	wire rst_fall    = ~sync_q[1] & prev_q[1];

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	localparam ST_IDLE  = 2'h0;
	localparam ST_CALC  = 2'h1;
	localparam ST_CLEAR = 2'h2;
	localparam ST_RESET = 2'h3;

	// Frame word targets and sub-targets
	localparam TGT_SPECIAL = 2'h3;
	localparam SUB_CTRL    = 2'h0;
	localparam SUB_MON     = 2'h1;
	localparam SUB_CLR     = 2'h2;

	reg [1:0]  state_q;
	reg [1:0]  state_d;
	reg [19:0] cnt_q;
	reg [19:0] cnt_d;
	reg        pend_q;
	reg        pend_d;
	reg        load_d;
	reg        clr_d;
	reg        rst_d;
	wire       frame_wr;
	wire       frame_data;

	always @* begin
		state_d = state_q;
		cnt_d   = cnt_q;
		pend_d  = pend_q;
		load_d  = 1'b0;
		clr_d   = 1'b0;
		rst_d   = 1'b0;
		// Reset edge beats clear, clear beats load, load beats a frame
		case (state_q)
			ST_IDLE: begin
				if (rst_fall) begin
					state_d = ST_RESET; // RQ11
					cnt_d   = RST_CYC[19:0] - 20'h1;
					pend_d  = 1'b0;
					rst_d   = 1'b1;
				end else if (clr_fall) begin
					state_d = ST_CLEAR; // RQ10
					cnt_d   = CLR_CYC[19:0] - 20'h1;
					pend_d  = 1'b0;
					clr_d   = 1'b1;
				end else if ((load_fall || pend_q) && !clr_low) begin
					load_d = 1'b1; // RQ6
					pend_d = 1'b0; // RQ20
				end else if (frame_data) begin
					// Only data frames start a calculation
					state_d = ST_CALC; // RQ5
					cnt_d   = CALC_CYC[19:0] - 20'h1;
				end
			end
			ST_CALC: begin
				if (load_fall && !clr_low)
					pend_d = 1'b1; // RQ7
				if (rst_fall) begin
					state_d = ST_RESET;
					cnt_d   = RST_CYC[19:0] - 20'h1;
					pend_d  = 1'b0;
					rst_d   = 1'b1;
				end else if (cnt_q == 20'h0)
					state_d = ST_IDLE;
				else
					cnt_d = cnt_q - 20'h1;
			end
			ST_CLEAR: begin
				if (rst_fall) begin
					state_d = ST_RESET;
					cnt_d   = RST_CYC[19:0] - 20'h1;
					rst_d   = 1'b1;
				end else if (cnt_q == 20'h0)
					state_d = ST_IDLE;
				else
					cnt_d = cnt_q - 20'h1;
			end
			ST_RESET: begin
				pend_d = 1'b0; // RQ12
				if (cnt_q == 20'h0)
					state_d = ST_IDLE; // RQ13
				else
					cnt_d = cnt_q - 20'h1;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q             <= ST_RESET; // RQ8
			cnt_q               <= 20'h0;
			pend_q              <= 1'b0;
			BUSY_N              <= 1'b0;
			LOAD_OUTPUTS_STROBE <= 1'b0;
			CLEAR_STROBE        <= 1'b0;
			REG_RESET_STROBE    <= 1'b0;
			POWER_DOWN_ACTIVE   <= 1'b0;
		end else begin
			state_q             <= state_d;
			cnt_q               <= cnt_d;
			pend_q              <= pend_d;
			BUSY_N              <= (state_d == ST_IDLE); // RQ12
			LOAD_OUTPUTS_STROBE <= load_d;
			CLEAR_STROBE        <= clr_d; // RQ9
			REG_RESET_STROBE    <= rst_d;
			POWER_DOWN_ACTIVE   <= sync_q[0];
		end
	end

	// ----------------------------------------
	// Serial interface
	// ----------------------------------------
	// Interface runs regardless of power-down, but not during reset
	wire if_enable = (state_q != ST_RESET) && serial_mode; // RQ19
	reg  [4:0]  bitcnt_q;
	reg  [23:0] shift_q;
	reg         wr_q;

	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bitcnt_q <= 5'h0;
			shift_q  <= 24'h0;
			wr_q     <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			// A frame cut short by frame select rising is dropped
			if (!if_enable || frame_n) begin
				bitcnt_q <= 5'h0; // RQ1
			end else if (sclk_fall) begin
				shift_q <= {shift_q[22:0], sdin}; // RQ18
				if (bitcnt_q == `DUCR_FRAME_BITS - 1) begin
					bitcnt_q <= 5'h0;
					wr_q     <= 1'b1; // RQ1
				end else
					bitcnt_q <= bitcnt_q + 5'h1;
			end
		end
	end
	assign frame_wr = wr_q;
	assign frame_data = frame_wr && (shift_q[23:22] != TGT_SPECIAL);

	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SERIAL_DATA_OUT    <= 1'b0;
			SERIAL_DATA_OUT_OE <= 1'b0;
			FRAME_DONE         <= 1'b0;
			FRAME_WORD         <= 24'h0;
			BUS_ADDRESS        <= 2'h0;
		end else begin
			SERIAL_DATA_OUT_OE <= if_enable && cascade && !frame_n; // RQ3
			// Between frames the first bit stands before any clock edge
			if (frame_n)
				SERIAL_DATA_OUT <= shift_q[23];
			else if (sclk_rise)
				SERIAL_DATA_OUT <= shift_q[23]; // RQ4
			FRAME_DONE <= wr_q;
			if (wr_q)
				FRAME_WORD <= shift_q;
			// Address pins are latched only in two-wire mode
			if (!serial_mode)
				BUS_ADDRESS <= {cascade, frame_n}; // RQ2 RQ17
		end
	end

	// ----------------------------------------
	// Monitor, reference and clear code
	// ----------------------------------------
	// Frame word: [23:22] target 2'b11 selects control/monitor/clear code
	// [21:20] sub: 0 control, 1 monitor select, 2 clear code
	wire special = wr_q && (shift_q[23:22] == TGT_SPECIAL);
	// Channels plus the two monitor inputs; higher codes are refused
	wire [31:0] mon_lim_w = CHANNELS + 2;
	wire [4:0]  mon_lim   = mon_lim_w[4:0];

	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			INTERNAL_REF_ENABLE <= 1'b0; // RQ16
			MONITOR_ENABLE      <= 1'b0;
			MONITOR_SELECT      <= `DUCR_MON_RST;
			CLEAR_CODE          <= `DUCR_CLRCODE_RST;
		// The clear code survives a reset sequence
		end else if (rst_d) begin
			INTERNAL_REF_ENABLE <= 1'b0;
			MONITOR_ENABLE      <= 1'b0;
			MONITOR_SELECT      <= `DUCR_MON_RST;
		end else if (special) begin
			case (shift_q[21:20])
				SUB_CTRL: begin
					INTERNAL_REF_ENABLE <= shift_q[`DUCR_CTRL_INTREF]; // RQ16
					MONITOR_ENABLE      <= shift_q[`DUCR_CTRL_MONEN];
				end
				SUB_MON: begin
					if (shift_q[4:0] < mon_lim)
						MONITOR_SELECT <= shift_q[4:0]; // RQ14 RQ15
				end
				SUB_CLR: CLEAR_CODE <= shift_q[13:0]; // RQ10
				default: ;
			endcase
		end
	end

endmodule
`default_nettype wire

// file: ducr_props.sv
// Checker of port timing for the update, clear and reset control block.
// Assumes the bench's small counts: CALC_CYC 40, CLR_CYC 10, RST_CYC 20.
`timescale 1ns/1ps
`default_nettype none
module ducr_props (
	input wire logic        CORE_CLK, RST_N, SERIAL_CLK, CASCADE_ENABLE_ADDR_BIT1,
	input wire logic        CLEAR_TO_CODE_N, RESET_PIN_N, POWER_DOWN, SERIAL_DATA_OUT,
	input wire logic        SERIAL_DATA_OUT_OE, BUSY_N, LOAD_OUTPUTS_STROBE, CLEAR_STROBE,
	input wire logic        REG_RESET_STROBE, FRAME_DONE, POWER_DOWN_ACTIVE,
	input wire logic [23:0] FRAME_WORD
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_low; !BUSY_N [*8]; endsequence
	property p_calc; FRAME_DONE && FRAME_WORD[23:22] != 2'h3 |=> ##1 s_low; endproperty
	property p_ldb; LOAD_OUTPUTS_STROBE |-> BUSY_N && $past(BUSY_N); endproperty
	property p_ldc; !CLEAR_TO_CODE_N [*5] |-> !LOAD_OUTPUTS_STROBE; endproperty
	property p_clr; CLEAR_STROBE |-> !BUSY_N ##1 s_low; endproperty
	property p_rst; $fell(RESET_PIN_N) |-> ##[2:5] REG_RESET_STROBE; endproperty
	property p_rsb; REG_RESET_STROBE |-> !BUSY_N ##1 s_low; endproperty
	property p_oe; !CASCADE_ENABLE_ADDR_BIT1 [*5] |-> !SERIAL_DATA_OUT_OE; endproperty
	property p_sdo; !SERIAL_CLK [*6] |-> $stable(SERIAL_DATA_OUT); endproperty
	property p_pd; POWER_DOWN [*4] |-> POWER_DOWN_ACTIVE; endproperty
	a_calc: assert property (p_calc) else $error("busy short after data frame");
	a_ldb: assert property (p_ldb) else $error("load strobe while busy");
	a_ldc: assert property (p_ldc) else $error("load strobe while clear low");
	a_clr: assert property (p_clr) else $error("busy short after clear");
	a_rst: assert property (p_rst) else $error("reset edge not taken");
	a_rsb: assert property (p_rsb) else $error("busy short after reset");
	a_oe: assert property (p_oe) else $error("serial out driven without cascade");
	a_sdo: assert property (p_sdo) else $error("serial out moved with clock low");
	a_pd: assert property (p_pd) else $error("power down not mirrored");
endmodule
bind ducr_control ducr_props u_props (
	.CORE_CLK                 (CORE_CLK),
	.RST_N                    (RST_N),
	.SERIAL_CLK               (SERIAL_CLK),
	.CASCADE_ENABLE_ADDR_BIT1 (CASCADE_ENABLE_ADDR_BIT1),
	.CLEAR_TO_CODE_N          (CLEAR_TO_CODE_N),
	.RESET_PIN_N              (RESET_PIN_N),
	.POWER_DOWN               (POWER_DOWN),
	.SERIAL_DATA_OUT          (SERIAL_DATA_OUT),
	.SERIAL_DATA_OUT_OE       (SERIAL_DATA_OUT_OE),
	.BUSY_N                   (BUSY_N),
	.LOAD_OUTPUTS_STROBE      (LOAD_OUTPUTS_STROBE),
	.CLEAR_STROBE             (CLEAR_STROBE),
	.REG_RESET_STROBE         (REG_RESET_STROBE),
	.FRAME_DONE               (FRAME_DONE),
	.POWER_DOWN_ACTIVE        (POWER_DOWN_ACTIVE),
	.FRAME_WORD               (FRAME_WORD)
);
`default_nettype wire

// file: ducr_host.sv
// Host model: drives serial frames, clock idle high between frames.
`timescale 1ns/1ps
`default_nettype none
module ducr_host (
	output logic sclk,
	output logic sdi,
	output logic sync_n
);
	initial begin
		sclk = 1'b1;
		sdi = 1'b0;
		sync_n = 1'b1;
	end
	task automatic send(input logic [23:0] w);
		sync_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi = w[i];
			#32 sclk = 1'b0;
			#32 sclk = 1'b1;
		end
		#32 sync_n = 1'b1;
		sdi = ~sdi;
		// Frame select stays high for a gap before the next frame
		#64;
	endtask
endmodule
`default_nettype wire

// file: ducr_control_tb.sv
// Self-checking bench of the control block; host model drives frames.
`timescale 1ns/1ps
`default_nettype none
module ducr_control_tb;
	logic CORE_CLK, RST_N, INTERFACE_SERIAL, CASCADE_ENABLE_ADDR_BIT1, a0;
	logic LOAD_OUTPUTS_N, CLEAR_TO_CODE_N, RESET_PIN_N, POWER_DOWN;
	wire SERIAL_CLK, SERIAL_DATA_IN, sync_n, SERIAL_DATA_OUT, SERIAL_DATA_OUT_OE, BUSY_N;
	wire LOAD_OUTPUTS_STROBE, CLEAR_STROBE, REG_RESET_STROBE, FRAME_DONE, POWER_DOWN_ACTIVE;
	wire MONITOR_ENABLE, INTERNAL_REF_ENABLE;
	wire [23:0] FRAME_WORD;
	wire [1:0] BUS_ADDRESS;
	wire [4:0] MONITOR_SELECT;
	wire [13:0] CLEAR_CODE;
	wire FRAME_SELECT_ADDR_BIT0 = INTERFACE_SERIAL ? sync_n : a0;
	int miscompares = 0, n_checks = 0, cyc = 0, nl, bc;
	always #2 CORE_CLK = ~CORE_CLK;
	ducr_host HOST (.sclk(SERIAL_CLK), .sdi(SERIAL_DATA_IN), .sync_n(sync_n));
	ducr_control #(.RST_CYC(20), .CLR_CYC(10), .CALC_CYC(40)) DUT (
		.CORE_CLK                 (CORE_CLK),
		.RST_N                    (RST_N),
		.INTERFACE_SERIAL         (INTERFACE_SERIAL),
		.SERIAL_CLK               (SERIAL_CLK),
		.SERIAL_DATA_IN           (SERIAL_DATA_IN),
		.FRAME_SELECT_ADDR_BIT0   (FRAME_SELECT_ADDR_BIT0),
		.CASCADE_ENABLE_ADDR_BIT1 (CASCADE_ENABLE_ADDR_BIT1),
		.LOAD_OUTPUTS_N           (LOAD_OUTPUTS_N),
		.CLEAR_TO_CODE_N          (CLEAR_TO_CODE_N),
		.RESET_PIN_N              (RESET_PIN_N),
		.POWER_DOWN               (POWER_DOWN),
		.SERIAL_DATA_OUT          (SERIAL_DATA_OUT),
		.SERIAL_DATA_OUT_OE       (SERIAL_DATA_OUT_OE),
		.BUSY_N                   (BUSY_N),
		.LOAD_OUTPUTS_STROBE      (LOAD_OUTPUTS_STROBE),
		.CLEAR_STROBE             (CLEAR_STROBE),
		.REG_RESET_STROBE         (REG_RESET_STROBE),
		.FRAME_DONE               (FRAME_DONE),
		.FRAME_WORD               (FRAME_WORD),
		.BUS_ADDRESS              (BUS_ADDRESS),
		.POWER_DOWN_ACTIVE        (POWER_DOWN_ACTIVE),
		.MONITOR_ENABLE           (MONITOR_ENABLE),
		.MONITOR_SELECT           (MONITOR_SELECT),
		.INTERNAL_REF_ENABLE      (INTERNAL_REF_ENABLE),
		.CLEAR_CODE               (CLEAR_CODE)
	);
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(negedge CORE_CLK);
	endtask
	task automatic lcount(input int n);
		nl = 0;
		repeat (n) @(negedge CORE_CLK) nl += LOAD_OUTPUTS_STROBE;
	endtask
	task automatic blow;
		bc = 0;
		@(negedge CORE_CLK iff !BUSY_N);
		while (!BUSY_N) begin
			bc++;
			tk(1);
		end
	endtask
	task automatic t_cfg;
		chk("iref", 0, INTERNAL_REF_ENABLE);
		HOST.send(24'hc00003);
		chk("iref", 1, INTERNAL_REF_ENABLE);
		chk("monen", 1, MONITOR_ENABLE);
		HOST.send(24'hd00011);
		chk("msel", 24'h11, MONITOR_SELECT);
		HOST.send(24'hd00012);
		chk("msel", 24'h11, MONITOR_SELECT);
		HOST.send(24'he01234);
		chk("word", 24'he01234, FRAME_WORD);
		chk("ccode", 24'h1234, CLEAR_CODE);
		$display("cfg done");
	endtask
	task automatic t_load;
		fork HOST.send(24'h400000); join_none
		@(negedge CORE_CLK iff FRAME_DONE);
		LOAD_OUTPUTS_N = 0;
		tk(4);
		LOAD_OUTPUTS_N = 1;
		tk(4);
		LOAD_OUTPUTS_N = 0;
		lcount(20);
		chk("ld calc", 0, nl);
		lcount(40);
		chk("ld deferred", 1, nl);
		LOAD_OUTPUTS_N = 1;
		tk(4);
		LOAD_OUTPUTS_N = 0;
		lcount(8);
		chk("ld idle", 1, nl);
		LOAD_OUTPUTS_N = 1;
		$display("load done");
	endtask
	task automatic t_clear;
		CLEAR_TO_CODE_N = 0;
		blow;
		chk("clr busy", 10, bc);
		LOAD_OUTPUTS_N = 0;
		lcount(10);
		chk("ld clr", 0, nl);
		LOAD_OUTPUTS_N = 1;
		CLEAR_TO_CODE_N = 1;
		tk(4);
		$display("clear done");
	endtask
	task automatic t_rpin;
		RESET_PIN_N = 0;
		fork blow; join_none
		tk(6);
		LOAD_OUTPUTS_N = 0;
		wait fork;
		chk("rst busy", 20, bc);
		chk("monen", 0, MONITOR_ENABLE);
		lcount(8);
		chk("ld rst", 0, nl);
		LOAD_OUTPUTS_N = 1;
		tk(4);
		LOAD_OUTPUTS_N = 0;
		lcount(8);
		chk("ld after", 1, nl);
		LOAD_OUTPUTS_N = 1;
		RESET_PIN_N = 1;
		$display("reset pin done");
	endtask
	task automatic t_mode;
		logic [23:0] sw;
		INTERFACE_SERIAL = 0;
		a0 = 1;
		POWER_DOWN = 1;
		tk(6);
		chk("addr", 1, BUS_ADDRESS);
		chk("pd", 1, POWER_DOWN_ACTIVE);
		a0 = 0;
		CASCADE_ENABLE_ADDR_BIT1 = 1;
		tk(6);
		chk("addr", 2, BUS_ADDRESS);
		INTERFACE_SERIAL = 1;
		tk(4);
		fork HOST.send(24'h000003); join_none
		for (int i = 23; i >= 0; i--) begin
			@(negedge SERIAL_CLK);
			sw[i] = SERIAL_DATA_OUT;
		end
		chk("sdo", 24'h400000, sw);
		chk("oe", 1, SERIAL_DATA_OUT_OE);
		wait fork;
		$display("mode done");
	endtask
	task automatic t_por;
		RST_N = 0;
		tk(5);
		chk("por busy", 0, BUSY_N);
		RST_N = 1;
		@(negedge CORE_CLK iff BUSY_N);
		chk("ccode", 0, CLEAR_CODE);
		chk("msel", 0, MONITOR_SELECT);
		chk("iref", 0, INTERNAL_REF_ENABLE);
		$display("power-on reset done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	initial begin
		CORE_CLK = 1'b0;
		RST_N = 1'b0;
		INTERFACE_SERIAL = 1'b1;
		CASCADE_ENABLE_ADDR_BIT1 = 1'b0;
		a0 = 1'b0;
		LOAD_OUTPUTS_N = 1'b1;
		CLEAR_TO_CODE_N = 1'b1;
		RESET_PIN_N = 1'b1;
		POWER_DOWN = 1'b0;
		tk(5);
		RST_N = 1;
		@(negedge CORE_CLK iff BUSY_N);
		tk(3);
		t_cfg;
		t_load;
		t_clear;
		t_rpin;
		t_mode;
		t_por;
		tally_and_finish;
	end
endmodule
`default_nettype wire
